// ==== design/smbx_pkg.sv ====
// Package: constants for the SMBus extension logic
package smbx_pkg;
    // Reserved 7-bit addresses
    localparam logic [6:0] SMBX_ADDR_DEFAULT  = 7'h61;   // 0b1100 001
    localparam logic [6:0] SMBX_ADDR_HOST     = 7'h08;   // 0b0001 000
    localparam logic [6:0] SMBX_ADDR_ALERT    = 7'h0C;   // 0b0001 100
    // CRC-8 x^8+x^2+x+1
    localparam logic [7:0] SMBX_CRC_POLY      = 8'h07;
    localparam logic [7:0] SMBX_CRC_INIT      = 8'h00;
    // Timer prescales in kernel clocks
    localparam int         SMBX_LOW_PRESC     = 2048;
    localparam int         SMBX_IDLE_PRESC    = 4;
    localparam logic [10:0] SMBX_PRESC_LAST_LOW  = 11'h7FF;  // 2048-1
    localparam logic [10:0] SMBX_PRESC_LAST_IDLE = 11'h003;  // 4-1
    localparam int         SMBX_RELOAD_W      = 12;
    localparam int         SMBX_CNT_W         = 13;
    // Timer state machine, Gray coded
    typedef enum logic [1:0]
    {
        SMBX_T_OFF   = 2'b00,
        SMBX_T_RUN   = 2'b01,
        SMBX_T_FIRED = 2'b11
    } smbx_tstate_e;
endpackage : smbx_pkg

// ==== design/smbx_crc8.sv ====
// CRC-8 packet error code accumulator, one byte per strobe
`timescale 1ns/1ps
module smbx_crc8
    import smbx_pkg::*;
(
    input  wire logic       clk_i,     // Kernel clock
    input  wire logic       rst_n_i,   // Sync reset, active low
    input  wire logic       clear_i,   // Restart accumulation
    input  wire logic       byte_i,    // Byte strobe
    input  wire logic [7:0] data_i,    // Byte on the bus
    output logic      [7:0] crc_o      // Running code
);
    logic [7:0] crc_reg;
    logic [7:0] crc_next;
    logic [7:0] stage [0:8];

    // ------------------------------------------------------------
    // Bitwise CRC, msb first
    // ------------------------------------------------------------
    assign stage[0] = crc_reg ^ data_i;
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_bit
            assign stage[g+1] = stage[g][7] ? ((stage[g] << 1) ^ SMBX_CRC_POLY)
                                            : (stage[g] << 1);
        end
    endgenerate
    assign crc_next = stage[8];

    // Clear wins so a START with a byte still pending starts clean
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || clear_i)
            crc_reg <= SMBX_CRC_INIT;
        else if (byte_i)
            crc_reg <= crc_next;
    end

    assign crc_o = crc_reg;
endmodule : smbx_crc8

// ==== design/smbx_ext.sv ====
// SMBus extension logic: addresses, alert, PEC, byte ACK, arbitration, timers
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module smbx_ext
    import smbx_pkg::*;
(
    input  wire logic        clk_i,                 // Kernel clock, 100 MHz
    input  wire logic        rst_n_i,               // Sync reset, active low
    // Configuration
    input  wire logic        default_addr_enable_i, // Device default address on
    input  wire logic        host_role_enable_i,    // Host role, host address on
    input  wire logic        attention_enable_i,    // Alert function on
    input  wire logic        fault_irq_enable_i,    // Alert interrupt enable
    input  wire logic        per_byte_ack_control_i,// Slave byte ACK control
    input  wire logic        pec_enable_i,          // PEC check enable
    input  wire logic        timeout_enable_i,      // Timer A enable
    input  wire logic        idle_check_select_i,   // 1 idle detect, 0 clock low
    input  wire logic [11:0] low_idle_reload_i,     // Timer A reload
    input  wire logic        ext_enable_i,          // Timer B enable
    input  wire logic [11:0] ext_reload_i,          // Timer B reload
    // From the base engine
    input  wire logic        start_i,               // START seen, pulse
    input  wire logic        stop_i,                // STOP seen, pulse
    input  wire logic        ack_slot_i,            // ACK bit seen, pulse
    input  wire logic        slave_mode_i,          // Engine acts as slave
    input  wire logic        addr_valid_i,          // Address byte received, pulse
    input  wire logic [6:0]  addr_i,                // Received 7-bit address
    input  wire logic        byte_done_i,           // Byte complete, pulse
    input  wire logic [7:0]  byte_i,                // Byte complete value
    input  wire logic        pec_byte_i,            // This byte is the check byte
    input  wire logic        sw_nack_i,             // Software NACK for byte
    input  wire logic        sda_drive_high_i,      // Engine releases SDA
    input  wire logic        self_stretch_i,        // Engine holds SCL low
    input  wire logic        scl_i,                 // SCL level
    input  wire logic        sda_i,                 // SDA level
    input  wire logic        attention_line_n_i,    // Attention pin level
    input  wire logic        alert_clear_i,         // Clear alert flag, pulse
    input  wire logic        timeout_clear_i,       // Clear timeout flag, pulse
    // To the base engine and software
    output logic             addr_match_o,          // Reserved address hit
    output logic             byte_nack_o,           // NACK current byte
    output logic             pec_error_o,           // Check byte mismatch, sticky
    output logic             arb_lost_o,            // Lost arbitration, sticky
    output logic [7:0]       pec_o,                 // Running PEC
    output logic             attention_line_n_o,    // Attention pin output value
    output logic             attention_line_n_oe_n_o,// Attention pin enable, low drives
    output logic             alert_flag_o,          // Alert event, sticky
    output logic             alert_irq_o,           // Alert interrupt
    output logic             timeout_flag_o,        // Timeout event, sticky
    output logic             bus_idle_o             // Bus idle detected
);
    logic       att_reg;
    logic       att_prev_reg;
    logic       alert_flag_reg;
    logic       match_reg;
    logic       nack_reg;
    logic       pec_err_reg;
    logic       arb_reg;
    logic       idle_reg;
    logic       tflag_reg;
    logic       att_internal;
    logic       pull_alert;
    logic       hit;
    logic       pec_mismatch;
    logic [7:0] crc;
    smbx_tstate_e ta_state_reg;
    logic [10:0] ta_pre_reg;
    logic [SMBX_CNT_W-1:0] ta_cnt_reg;
    logic [10:0] tb_pre_reg;
    logic [SMBX_CNT_W-1:0] tb_cnt_reg;
    logic       ta_cond;
    logic       ta_fire;
    logic       tb_fire;
    logic [10:0] ta_last;

    // ------------------------------------------------------------
    // Packet error code
    // ------------------------------------------------------------
    // Address byte is hashed with its R/W bit; START restarts the code
    smbx_crc8 u_crc
    (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clear_i (start_i),
        .byte_i  (byte_done_i && !pec_byte_i),
        .data_i  (byte_i),
        .crc_o   (crc)
    );
    assign pec_mismatch = pec_enable_i && pec_byte_i && (byte_i != crc);

    // ------------------------------------------------------------
    // Alert line
    // ------------------------------------------------------------
    // Slave pulls the line only while not in host role
    assign pull_alert = attention_enable_i && !host_role_enable_i;
    // Disabled alert reads high, pin stays free for other use
    assign att_internal = attention_enable_i ? att_reg : 1'b1;

    // Pin sampled once; edge taken from registered copies only
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            att_reg      <= 1'b1;
            att_prev_reg <= 1'b1;
        end
        else
        begin
            att_reg      <= attention_line_n_i;
            att_prev_reg <= att_internal;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            alert_flag_reg <= 1'b0;
        else if (host_role_enable_i && attention_enable_i
                 && att_prev_reg && !att_internal)
            alert_flag_reg <= 1'b1;
        else if (alert_clear_i)
            alert_flag_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Reserved address recognition
    // ------------------------------------------------------------
    // Host address answered only in host role, so the notifier is master
    always_comb
    begin
        hit = 1'b0;
        if (default_addr_enable_i && addr_i == SMBX_ADDR_DEFAULT)
            hit = 1'b1;
        if (host_role_enable_i && addr_i == SMBX_ADDR_HOST)
            hit = 1'b1;
        if (pull_alert && addr_i == SMBX_ADDR_ALERT)
            hit = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || start_i || stop_i)
            match_reg <= 1'b0;
        else if (addr_valid_i)
            match_reg <= hit;
    end

    // ------------------------------------------------------------
    // Byte acknowledge control
    // ------------------------------------------------------------
    // Held for the byte's ACK slot; mismatch NACKs regardless of software
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || start_i)
            nack_reg <= 1'b0;
        else if (byte_done_i)
            nack_reg <= pec_mismatch
                        || (slave_mode_i && per_byte_ack_control_i
                            && sw_nack_i && !pec_byte_i);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            pec_err_reg <= 1'b0;
        else if (byte_done_i && pec_mismatch)
            pec_err_reg <= 1'b1;
        else if (start_i)
            pec_err_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Slave arbitration
    // ------------------------------------------------------------
    // Sampled on SCL high: released SDA seen low means another slave won
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            arb_reg <= 1'b0;
        else if (slave_mode_i && scl_i && sda_drive_high_i && !sda_i)
            arb_reg <= 1'b1;
        else if (start_i || stop_i)
            arb_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Timer A: clock low timeout or bus idle
    // ------------------------------------------------------------
    // Limitation: reload must be set for 25..35 ms by software
    assign ta_cond = idle_check_select_i ? (scl_i && sda_i)
                                         : !scl_i;
    assign ta_last = idle_check_select_i ? SMBX_PRESC_LAST_IDLE
                                         : SMBX_PRESC_LAST_LOW;
    // Fires once (reload+1) whole prescaler periods have elapsed
    assign ta_fire = (ta_pre_reg == ta_last)
                     && (ta_cnt_reg == {1'b0, low_idle_reload_i});

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !timeout_enable_i || !ta_cond)
        begin
            ta_state_reg <= SMBX_T_OFF;
            ta_pre_reg   <= '0;
            ta_cnt_reg   <= '0;
        end
        else
        begin
            case (ta_state_reg)
                SMBX_T_OFF:
                    ta_state_reg <= SMBX_T_RUN;
                SMBX_T_RUN:
                begin
                    if (ta_fire)
                        ta_state_reg <= SMBX_T_FIRED;
                    else if (ta_pre_reg == ta_last)
                    begin
                        ta_pre_reg <= '0;
                        ta_cnt_reg <= ta_cnt_reg + 1'b1;
                    end
                    else
                        ta_pre_reg <= ta_pre_reg + 1'b1;
                end
                SMBX_T_FIRED:
                    ta_state_reg <= SMBX_T_FIRED;
                default:
                    ta_state_reg <= SMBX_T_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            idle_reg <= 1'b0;
        else
            idle_reg <= idle_check_select_i && (ta_state_reg == SMBX_T_FIRED);
    end

    // ------------------------------------------------------------
    // Timer B: cumulative own stretch
    // ------------------------------------------------------------
    // Slave window is the whole message, master window is one byte
    assign tb_fire = (tb_pre_reg == SMBX_PRESC_LAST_LOW)
                     && (tb_cnt_reg == {1'b0, ext_reload_i});

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i || !ext_enable_i || start_i || stop_i
            || (!slave_mode_i && ack_slot_i))
        begin
            tb_pre_reg <= '0;
            tb_cnt_reg <= '0;
        end
        else if (self_stretch_i && !scl_i && !tb_fire)
        begin
            if (tb_pre_reg == SMBX_PRESC_LAST_LOW)
            begin
                tb_pre_reg <= '0;
                tb_cnt_reg <= tb_cnt_reg + 1'b1;
            end
            else
                tb_pre_reg <= tb_pre_reg + 1'b1;
        end
    end

    // Set wins over a same-cycle clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            tflag_reg <= 1'b0;
        else if ((timeout_enable_i && ta_cond && ta_state_reg == SMBX_T_RUN && ta_fire)
                 || (ext_enable_i && self_stretch_i && !scl_i && tb_fire))
            tflag_reg <= 1'b1;
        else if (timeout_clear_i)
            tflag_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign addr_match_o            = match_reg;
    assign byte_nack_o             = nack_reg;
    assign pec_error_o             = pec_err_reg;
    assign arb_lost_o              = arb_reg;
    assign pec_o                   = crc;
    assign attention_line_n_o      = 1'b0;
    assign attention_line_n_oe_n_o = !pull_alert;
    assign alert_flag_o            = alert_flag_reg;
    assign alert_irq_o             = alert_flag_reg && fault_irq_enable_i;
    assign timeout_flag_o          = tflag_reg;
    assign bus_idle_o              = idle_reg;
endmodule : smbx_ext

// ==== dv/smbx_ext_asserts.sv ====
// Port-level checks for the SMBus extension logic
`timescale 1ns/1ps
module smbx_ext_asserts
    import smbx_pkg::*;
(
    input wire logic       clk_i,                   // Clock
    input wire logic       rst_n_i,                 // Reset
    input wire logic       default_addr_enable_i,   // Cfg
    input wire logic       host_role_enable_i,      // Cfg
    input wire logic       attention_enable_i,      // Cfg
    input wire logic       per_byte_ack_control_i,  // Cfg
    input wire logic       pec_enable_i,            // Cfg
    input wire logic       start_i,                 // Engine
    input wire logic       slave_mode_i,            // Engine
    input wire logic       addr_valid_i,            // Engine
    input wire logic [6:0] addr_i,                  // Engine
    input wire logic       byte_done_i,             // Engine
    input wire logic [7:0] byte_i,                  // Engine
    input wire logic       pec_byte_i,              // Engine
    input wire logic       sw_nack_i,               // Engine
    input wire logic       sda_drive_high_i,        // Engine
    input wire logic       scl_i,                   // Bus
    input wire logic       sda_i,                   // Bus
    input wire logic       attention_line_n_i,      // Pin
    input wire logic       addr_match_o,            // Out
    input wire logic       byte_nack_o,             // Out
    input wire logic       pec_error_o,             // Out
    input wire logic       arb_lost_o,              // Out
    input wire logic [7:0] pec_o,                   // Out
    input wire logic       attention_line_n_oe_n_o, // Out
    input wire logic       alert_flag_o             // Out
);
    // ----------
    // Checks
    // ----------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Host sees the pin fall while alerts are on
    sequence att_fall;
        host_role_enable_i && attention_enable_i && $fell(attention_line_n_i);
    endsequence
    // Check byte that disagrees with the running code
    sequence bad_check;
        byte_done_i && pec_byte_i && pec_enable_i && byte_i != pec_o;
    endsequence
    dflt_match_a: assert property (addr_valid_i && default_addr_enable_i
        && addr_i == SMBX_ADDR_DEFAULT |=> addr_match_o) else $error("default addr missed");
    host_match_a: assert property (addr_valid_i && host_role_enable_i
        && addr_i == SMBX_ADDR_HOST |=> addr_match_o) else $error("host addr missed");
    pin_drive_a: assert property (attention_line_n_oe_n_o ==
        !(attention_enable_i && !host_role_enable_i)) else $error("pin enable wrong");
    alert_resp_a: assert property (addr_valid_i && addr_i == SMBX_ADDR_ALERT
        |=> addr_match_o == !$past(attention_line_n_oe_n_o)) else $error("alert addr wrong");
    alert_flag_a: assert property (att_fall |-> ##[1:2] alert_flag_o)
        else $error("alert edge lost");
    alert_off_a: assert property (!attention_enable_i [*3] |-> !$rose(alert_flag_o))
        else $error("alert with pin off");
    pec_nack_a: assert property (bad_check |=> byte_nack_o && pec_error_o)
        else $error("check byte not refused");
    pec_clear_a: assert property (start_i |=> pec_o == 8'h00)
        else $error("code not cleared");
    byte_nack_a: assert property (byte_done_i && !pec_byte_i |=> byte_nack_o ==
        $past(slave_mode_i && per_byte_ack_control_i && sw_nack_i)) else $error("byte nack");
    arb_loss_a: assert property (slave_mode_i && scl_i && sda_drive_high_i && !sda_i
        |=> arb_lost_o) else $error("arbitration loss missed");
endmodule : smbx_ext_asserts

// ==== dv/smbx_far_model.sv ====
// Far side of the bus: other masters, slaves and hosts on shared lines
`timescale 1ns/1ps
module smbx_far_model
(
    input  wire logic att_pull_i, // Far device pulls attention low
    input  wire logic scl_pull_i, // Far master holds clock low
    input  wire logic sda_pull_i, // Far device drives data low
    input  wire logic att_val_i,  // Our pin value
    input  wire logic att_oe_n_i, // Our pin enable, low drives
    output logic      att_n_o,    // Attention line level
    output logic      scl_o,      // Clock line level
    output logic      sda_o       // Data line level
);
    // Open-drain lines with pull-ups; released lines read high, never stale
    assign att_n_o = !att_pull_i && (att_oe_n_i || att_val_i);
    assign scl_o   = !scl_pull_i;
    assign sda_o   = !sda_pull_i;
endmodule : smbx_far_model

// ==== dv/test_smbx_ext.sv ====
// Self-checking bench for the SMBus extension logic
`timescale 1ns/1ps
module test_smbx_ext
    import smbx_pkg::*;
;
    // ----------
    // Wiring
    // ----------
    logic        clk_i, rst_n_i, start, av, bd, pb, swn, slv, sdh, sst, aclr, tclr, ext_en;
    logic        p_att, p_scl, p_sda, att_n, scl, sda, att_o, att_oe_n, stop, ack;
    logic        addr_match_o, byte_nack_o, pec_error_o, arb_lost_o;
    logic        alert_flag_o, alert_irq_o, timeout_flag_o, bus_idle_o;
    logic [7:0]  cfg, bv, pec_o, e;
    logic [6:0]  addr;
    logic [11:0] rel_a, rel_b;
    int          num_errors, checks, n;
    // Rows: {address, default en, host en, alert en, expected hit}
    localparam logic [10:0] ROWS [8] = '{11'h619, 11'h610, 11'h085, 11'h080,
                                         11'h0C3, 11'h0C0, 11'h0C6, 11'h22E};
    // Write Byte frame as software builds it: address, command, data
    localparam logic [7:0]  MSG [3]  = '{8'hC2, 8'h05, 8'hA7};
    always #5 clk_i = ~clk_i;
    smbx_ext i_smbx_ext (.clk_i(clk_i), .rst_n_i(rst_n_i), .default_addr_enable_i(cfg[0]),
        .host_role_enable_i(cfg[1]), .attention_enable_i(cfg[2]), .fault_irq_enable_i(cfg[3]),
        .per_byte_ack_control_i(cfg[4]), .pec_enable_i(cfg[5]), .timeout_enable_i(cfg[6]),
        .idle_check_select_i(cfg[7]), .low_idle_reload_i(rel_a), .ext_enable_i(ext_en),
        .ext_reload_i(rel_b), .start_i(start), .stop_i(stop), .ack_slot_i(ack),
        .slave_mode_i(slv), .addr_valid_i(av), .addr_i(addr), .byte_done_i(bd), .byte_i(bv),
        .pec_byte_i(pb), .sw_nack_i(swn), .sda_drive_high_i(sdh), .self_stretch_i(sst),
        .scl_i(scl), .sda_i(sda), .attention_line_n_i(att_n), .alert_clear_i(aclr),
        .timeout_clear_i(tclr), .addr_match_o(addr_match_o), .byte_nack_o(byte_nack_o),
        .pec_error_o(pec_error_o), .arb_lost_o(arb_lost_o), .pec_o(pec_o),
        .attention_line_n_o(att_o), .attention_line_n_oe_n_o(att_oe_n),
        .alert_flag_o(alert_flag_o), .alert_irq_o(alert_irq_o),
        .timeout_flag_o(timeout_flag_o), .bus_idle_o(bus_idle_o));
    smbx_far_model i_smbx_far_model (.att_pull_i(p_att), .scl_pull_i(p_scl),
        .sda_pull_i(p_sda), .att_val_i(att_o), .att_oe_n_i(att_oe_n), .att_n_o(att_n),
        .scl_o(scl), .sda_o(sda));
    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    // Wait k edges, then let that edge's updates land
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic go_start();
        @(posedge clk_i);
        start <= 1'b1;
        @(posedge clk_i);
        start <= 1'b0;
        #1;
    endtask : go_start
    task automatic send(input logic [7:0] b, input logic p);
        @(posedge clk_i);
        bd <= 1'b1;
        bv <= b;
        pb <= p;
        @(posedge clk_i);
        bd <= 1'b0;
        pb <= 1'b0;
        #1;
    endtask : send
    // Bounded wait for the timeout flag; n holds the edges it took
    task automatic wait_to(input int hi);
        n = 0;
        while (timeout_flag_o !== 1'b1)
        begin
            tick(1);
            n++;
            if (n > hi)
            begin
                num_errors++;
                end_of_test();
            end
        end
    endtask : wait_to
    // Bitwise CRC-8, msb first, written apart from the design
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++)
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        return r;
    endfunction : crc8
    // ----------
    // Sequence
    // ----------
    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        {start, av, bd, pb, swn, slv, sdh, sst, aclr, tclr, ext_en, p_att, p_scl, p_sda} = '0;
        {cfg, bv, addr, rel_a, rel_b, stop, ack} = '0;
        num_errors = 0;
        checks = 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        tick(1);
        chk({2'h0, addr_match_o, byte_nack_o, pec_error_o, arb_lost_o, alert_flag_o,
             timeout_flag_o} | pec_o, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge clk_i);
            {addr, cfg[0], cfg[1], cfg[2]} <= ROWS[k][10:1];
            start <= 1'b1;
            @(posedge clk_i);
            start <= 1'b0;
            av <= 1'b1;
            @(posedge clk_i);
            av <= 1'b0;
            #1;
            chk(addr_match_o, ROWS[k][0]);
            chk(att_oe_n, !(ROWS[k][1] && !ROWS[k][2]));
            chk(att_n, !(ROWS[k][1] && !ROWS[k][2]));
        end
        // Message code, a bad check byte, then a fresh message
        @(posedge clk_i);
        cfg <= 8'h20;
        go_start();
        e = 8'h00;
        foreach (MSG[i])
        begin
            send(MSG[i], 1'b0);
            e = crc8(e, MSG[i]);
            chk(pec_o, e);
        end
        send(e ^ 8'h01, 1'b1);
        chk({byte_nack_o, pec_error_o}, 8'h03);
        go_start();
        send(8'hC2, 1'b0);
        chk(pec_o, crc8(8'h00, 8'hC2));
        send(crc8(8'h00, 8'hC2), 1'b1);
        chk({byte_nack_o, pec_error_o}, 8'h00);
        @(posedge clk_i);
        {slv, swn} <= 2'h3;
        for (int k = 1; k >= 0; k--)
        begin
            @(posedge clk_i);
            cfg[4] <= k[0];
            send(8'h11, 1'b0);
            chk(byte_nack_o, 8'(k));
        end
        // Host alert: edge, mask, clear, then pin ignored when off
        @(posedge clk_i);
        {slv, swn} <= 2'h0;
        cfg <= 8'h06;
        @(posedge clk_i);
        p_att <= 1'b1;
        tick(3);
        chk({alert_flag_o, alert_irq_o}, 8'h02);
        @(posedge clk_i);
        cfg[3] <= 1'b1;
        #1;
        chk(alert_irq_o, 8'h01);
        @(posedge clk_i);
        {aclr, p_att, cfg[2]} <= 3'h4;
        @(posedge clk_i);
        {aclr, p_att} <= 2'h1;
        tick(4);
        chk(alert_flag_o, 8'h00);
        // Another slave's identifier bit wins during address resolution
        @(posedge clk_i);
        {cfg, p_att} <= 9'h000;
        {slv, sdh, p_sda} <= 3'h7;
        tick(2);
        chk(arb_lost_o, 8'h01);
        // STOP ends the lost frame and drops the sticky loss
        @(posedge clk_i);
        {slv, sdh, p_sda, stop} <= 4'h1;
        @(posedge clk_i);
        stop <= 1'b0;
        #1;
        chk(arb_lost_o, 8'h00);
        // Idle detect with a short reload, then clock-low timeout
        @(posedge clk_i);
        cfg <= 8'hC0;
        rel_a <= 12'h002;
        wait_to(30);
        chk(8'(n >= 12), 8'h01);
        tick(1);
        chk(bus_idle_o, 8'h01);
        @(posedge clk_i);
        {cfg, tclr} <= 9'h001;
        @(posedge clk_i);
        {cfg, tclr} <= 9'h080;
        rel_a <= 12'h000;
        p_scl <= 1'b1;
        #1;
        wait_to(2100);
        chk(8'(n >= 2048), 8'h01);
        // Cumulative stretch as master, then as slave
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk_i);
            {cfg, ext_en, tclr} <= 10'h001;
            @(posedge clk_i);
            {ext_en, sst, tclr} <= 3'h6;
            slv <= k[0];
            // Mid-stretch ACK restarts only the master's per-byte count
            repeat (1000) @(posedge clk_i);
            ack <= 1'b1;
            @(posedge clk_i);
            ack <= 1'b0;
            #1;
            wait_to(2100);
            chk(8'(n >= 1040), 8'h01);
            chk(8'(n >= 2048), 8'(k == 0));
        end
        end_of_test();
    end
endmodule : test_smbx_ext
bind smbx_ext smbx_ext_asserts i_smbx_ext_asserts (.clk_i, .rst_n_i, .default_addr_enable_i,
    .host_role_enable_i, .attention_enable_i, .per_byte_ack_control_i, .pec_enable_i,
    .start_i, .slave_mode_i, .addr_valid_i, .addr_i, .byte_done_i, .byte_i, .pec_byte_i,
    .sw_nack_i, .sda_drive_high_i, .scl_i, .sda_i, .attention_line_n_i, .addr_match_o,
    .byte_nack_o, .pec_error_o, .arb_lost_o, .pec_o, .attention_line_n_oe_n_o, .alert_flag_o);
